// File: design/dpc_consts.svh
// constants of the clock-enable power-state tracker
// assumes inclusion by bare name from package and modules
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// power-state indication codes
`define DPC_PWR_NORMAL 2'h0
`define DPC_PWR_APD 2'h1
`define DPC_PWR_PPD 2'h2
`define DPC_PWR_SREF 2'h3

// command codes on ras_n, cas_n, we_n with cs_n low
`define DPC_CMD_REF 3'h1
`define DPC_CMD_NOP 3'h7

// pin group width and synchroniser reset value
`define DPC_PIN_W 6
`define DPC_PIN_RST 6'h1e

`endif

// File: design/dpc_pkg.sv
// types of the clock-enable power-state tracker
// assumes dpc_consts.svh is reachable on the include path
`include "dpc_consts.svh"

package dpc_pkg;

    // power-state machine, one-hot
    typedef enum logic [4:0] {
        DPC_ST_NORMAL = 5'b00001,
        DPC_ST_PDPEND = 5'b00010,
        DPC_ST_APD = 5'b00100,
        DPC_ST_PPD = 5'b01000,
        DPC_ST_SREF = 5'b10000
    } dpc_state_e;

    // pins as sampled at one clock edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
    } dpc_pins_s;

    // status from the array core, same clock domain
    typedef struct packed {
        logic bank_open;
        logic op_busy;
        logic timing_ok;
    } dpc_core_s;

    // all state of the tracker
    typedef struct packed {
        dpc_state_e st;
        logic cke_prev;
        logic [1:0] pwr;
        logic cmd_valid;
        logic [2:0] cmd_code;
        logic odt_en;
        logic sref_exit;
        logic pd_exit;
    } dpc_top_s;

endpackage

// File: design/dpc_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes pins are asynchronous to mclk; rst synchronous active high
`include "dpc_consts.svh"

module dpc_sync #(
    parameter int W = `DPC_PIN_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dpc_sync_s;

    dpc_sync_s s_q;
    dpc_sync_s s_d;

    // first stage feeds only the second
    always_comb begin
        s_d = s_q;
        s_d.meta = din;
        s_d.stable = s_q.meta;
    end

    // register the stages
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= {RST_VAL, RST_VAL};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stable;

endmodule

// File: design/dpc_top.sv
// clock-enable driven power-state tracker of a ddr3 sdram
// assumes pins arrive asynchronously, core status on mclk
`include "dpc_consts.svh"

module dpc_top
    import dpc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic ras_n_pin,
    input wire logic cas_n_pin,
    input wire logic we_n_pin,
    input wire logic odt_pin,
    input wire dpc_core_s core,
    output logic [1:0] pwr_state,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic odt_en,
    output logic sref_exit,
    output logic pd_exit
);

    // ****************************************************
    // pin synchronisation
    // ****************************************************

    dpc_pins_s pins_raw;
    dpc_pins_s pins;
    logic [`DPC_PIN_W-1:0] pins_bits;

    // gather pins into one group
    always_comb begin
        pins_raw.cke = cke_pin;
        pins_raw.cs_n = cs_n_pin;
        pins_raw.ras_n = ras_n_pin;
        pins_raw.cas_n = cas_n_pin;
        pins_raw.we_n = we_n_pin;
        pins_raw.odt = odt_pin;
    end

    // two flops keep metastable pin levels away from the decode;
    // every pin sees the same two-edge delay, so a command and
    // its cke level stay lined up after synchronisation
    dpc_sync #(
        .W(`DPC_PIN_W),
        .RST_VAL(`DPC_PIN_RST)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .din(pins_raw),
        .dout(pins_bits)
    );

    assign pins = dpc_pins_s'(pins_bits);

    // ****************************************************
    // command decode
    // ****************************************************

    logic [2:0] cmd;
    logic is_nop;
    logic is_ref;
    logic cke_fall;
    logic cke_rise;
    logic cke_hold_hi;
    logic all_idle;

    // state register, declared ahead of the decode that reads it;
    // cke_prev holds the synced cke of the previous edge, so each
    // pair below compares two consecutive sampled edges
    dpc_top_s s_q;
    dpc_top_s s_d;

    // deselect and nop decode alike
    always_comb begin
        cmd = {pins.ras_n, pins.cas_n, pins.we_n};
        is_nop = pins.cs_n || (cmd == `DPC_CMD_NOP);
        is_ref = !pins.cs_n && (cmd == `DPC_CMD_REF);
    end

    // edge pairs from this edge and the previous one
    always_comb begin
        cke_fall = s_q.cke_prev && !pins.cke;
        cke_rise = !s_q.cke_prev && pins.cke;
        cke_hold_hi = s_q.cke_prev && pins.cke;
        // idle needs closed banks, no burst, timings met
        all_idle = !core.bank_open && !core.op_busy &&
            core.timing_ok && s_q.cke_prev;
    end

    // ****************************************************
    // power-state machine
    // ****************************************************

    // next state from cke pair and command
    always_comb begin
        s_d = s_q;
        s_d.cke_prev = pins.cke;
        s_d.cmd_valid = 1'b0;
        s_d.sref_exit = 1'b0;
        s_d.pd_exit = 1'b0;
        unique case (s_q.st)
            DPC_ST_NORMAL: begin
                if (cke_fall && is_ref && all_idle) begin
                    s_d.st = DPC_ST_SREF;
                end else if (cke_fall && is_nop) begin
                    if (core.op_busy) begin
                        s_d.st = DPC_ST_PDPEND;
                    end else if (core.bank_open) begin
                        s_d.st = DPC_ST_APD;
                    end else begin
                        s_d.st = DPC_ST_PPD;
                    end
                end else if (cke_hold_hi && !is_nop) begin
                    // commands pass on only with cke high twice
                    s_d.cmd_valid = 1'b1;
                    s_d.cmd_code = cmd;
                end
            end
            DPC_ST_PDPEND: begin
                if (cke_rise) begin
                    s_d.st = DPC_ST_NORMAL;
                    s_d.pd_exit = 1'b1;
                end else if (!core.op_busy) begin
                    // kind fixed once the operation ends
                    s_d.st = core.bank_open ? DPC_ST_APD :
                        DPC_ST_PPD;
                end
            end
            DPC_ST_APD, DPC_ST_PPD: begin
                // low on both edges keeps state
                if (cke_rise) begin
                    s_d.st = DPC_ST_NORMAL;
                    s_d.pd_exit = 1'b1;
                end
            end
            DPC_ST_SREF: begin
                // exit follows cke alone, command ignored
                if (pins.cke) begin
                    s_d.st = DPC_ST_NORMAL;
                    s_d.sref_exit = 1'b1;
                end
            end
            default: begin
                s_d.st = DPC_ST_NORMAL;
            end
        endcase
        // single indication follows the state
        unique case (s_d.st)
            DPC_ST_NORMAL: s_d.pwr = `DPC_PWR_NORMAL;
            DPC_ST_PDPEND: s_d.pwr = `DPC_PWR_APD;
            DPC_ST_APD: s_d.pwr = `DPC_PWR_APD;
            DPC_ST_PPD: s_d.pwr = `DPC_PWR_PPD;
            DPC_ST_SREF: s_d.pwr = `DPC_PWR_SREF;
            default: s_d.pwr = `DPC_PWR_NORMAL;
        endcase
        // no termination in self refresh
        s_d.odt_en = pins.odt && (s_d.st != DPC_ST_SREF);
    end

    // register the whole state; the synchroniser resets itself,
    // cke_prev starts low so a high cke after reset reads as a rise
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q.st <= DPC_ST_NORMAL;
            s_q.cke_prev <= 1'b0;
            s_q.pwr <= `DPC_PWR_NORMAL;
            s_q.cmd_valid <= 1'b0;
            s_q.cmd_code <= `DPC_CMD_NOP;
            s_q.odt_en <= 1'b0;
            s_q.sref_exit <= 1'b0;
            s_q.pd_exit <= 1'b0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************

    // every output straight from the state register
    assign pwr_state = s_q.pwr;
    assign cmd_valid = s_q.cmd_valid;
    assign cmd_code = s_q.cmd_code;
    assign odt_en = s_q.odt_en;
    assign sref_exit = s_q.sref_exit;
    assign pd_exit = s_q.pd_exit;

endmodule

// File: tb/dpc_ctl_model.sv
// controller model driving the sdram command pins
// assumes req from the bench, one mclk domain
module dpc_ctl_model
    import dpc_pkg::*;
(
    input wire logic mclk,
    input wire dpc_pins_s req,
    output dpc_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ns;
    dpc_pins_s nxt;
    initial pins = 6'h1e;
    // registers request; cmd floats while cke low; bench holds
    // each cke level for several edges
    always @(posedge mclk) begin
        nxt = req;
        if (!req.cke && !pins.cke) begin
            nxt.ras_n = ~pins.ras_n;
            nxt.we_n = ~pins.we_n;
        end else if (req.cke != pins.cke && req.ras_n) begin
            nxt.cs_n = 1'b1;
        end
        pins <= nxt;
    end
endmodule

// File: tb/dpc_top_props.sv
// port checks of the power-state tracker
// assumes bound onto dpc_top, one mclk domain
module dpc_top_props
    import dpc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic ras_n_pin,
    input wire logic cas_n_pin,
    input wire logic we_n_pin,
    input wire dpc_core_s core,
    input wire logic [1:0] pwr_state,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic odt_en,
    input wire logic sref_exit,
    input wire logic pd_exit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire [2:0] cmd = {ras_n_pin, cas_n_pin, we_n_pin};
    // ****
    // steps
    // ****
    sequence fall_s; !cke_pin && $past(cke_pin); endsequence
    sequence nop_s; cs_n_pin || cmd == 3'h7; endsequence
    sequence ref_s; !cs_n_pin && cmd == 3'h1; endsequence
    sequence idle_s(bo);
        pwr_state == 2'h0 && !core.op_busy && core.timing_ok
            && core.bank_open == bo;
    endsequence
    property cmd_p;
        logic [2:0] c;
        (cke_pin && $past(cke_pin) && !cs_n_pin && cmd != 3'h7
            && pwr_state == 2'h0, c = cmd)
            |-> ##3 cmd_valid && cmd_code == c;
    endproperty
    // ****
    // checks
    // ****
    sre_entry_a: assert property (
        fall_s ##0 ref_s ##2 idle_s(1'b0) |=> pwr_state == 2'h3)
        else $error("no sr entry");
    ppd_entry_a: assert property (
        fall_s ##0 nop_s ##2 idle_s(1'b0) |=> pwr_state == 2'h2)
        else $error("no ppd entry");
    apd_entry_a: assert property (
        fall_s ##0 nop_s ##2 idle_s(1'b1) |=> pwr_state == 2'h1)
        else $error("no apd entry");
    low_hold_a: assert property (
        !cke_pin [*3] ##0 pwr_state[1] |=> $stable(pwr_state) && !cmd_valid)
        else $error("low state left");
    sref_exit_a: assert property (
        pwr_state == 2'h3 && $rose(cke_pin)
            |-> ##3 pwr_state == 2'h0 && sref_exit ##1 !sref_exit)
        else $error("bad sr exit");
    pd_exit_a: assert property (
        pwr_state == 2'h2 && $rose(cke_pin)
            |-> ##3 pwr_state == 2'h0 && pd_exit && !sref_exit)
        else $error("bad pd exit");
    odt_off_a: assert property (
        pwr_state == 2'h3 |-> !odt_en)
        else $error("odt in sr");
    nop_quiet_a: assert property (
        nop_s |-> ##3 !cmd_valid)
        else $error("nop gave cmd");
    cmd_pass_a: assert property (cmd_p)
        else $error("cmd lost");
endmodule
bind dpc_top dpc_top_props dpc_top_props_inst (.mclk(mclk), .rst(rst),
    .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
    .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .core(core),
    .pwr_state(pwr_state), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .odt_en(odt_en), .sref_exit(sref_exit), .pd_exit(pd_exit));

// File: tb/dpc_top_bench.sv
// self-checking bench of the power-state tracker
// assumes dpc_ctl_model drives pins, bench drives core
module dpc_top_bench
    import dpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    dpc_pins_s req = 6'h1e;
    dpc_pins_s pins;
    dpc_core_s core = 3'h1;
    logic [1:0] pwr_state;
    logic [2:0] cmd_code;
    logic [2:0] code_exp = 3'h7;
    logic cmd_valid, odt_en, sref_exit, pd_exit;
    int num_errors = 0;
    int comparisons = 0;
    // rows: cs_n, command, expected valid
    logic [4:0] rows [9] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0b,
        5'h0d, 5'h0e, 5'h10};
    always #5 mclk = ~mclk;
    dpc_ctl_model dpc_ctl_model_inst (.mclk(mclk), .req(req), .pins(pins));
    dpc_top dpc_top_inst (.mclk(mclk), .rst(rst), .ce(ce),
        .cke_pin(pins.cke), .cs_n_pin(pins.cs_n), .ras_n_pin(pins.ras_n),
        .cas_n_pin(pins.cas_n), .we_n_pin(pins.we_n), .odt_pin(pins.odt),
        .core(core), .pwr_state(pwr_state), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .odt_en(odt_en), .sref_exit(sref_exit),
        .pd_exit(pd_exit));
    function automatic dpc_pins_s p(logic c, logic s, logic [2:0] m,
        logic o);
        return {c, s, m, o};
    endfunction
    // drive at an edge, then wait n edges
    task automatic go(dpc_pins_s r, dpc_core_s k, int n);
        @(posedge mclk);
        req <= r;
        core <= k;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(logic [3:0] got, logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #20000;
        num_errors++;
        wrap_up();
    end
    // ****
    // sequence
    // ****
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk({1'b0, odt_en, pwr_state}, 4'h0);
        chk({1'b0, cmd_code}, 4'h7);
        go(p(1, 0, 3'h7, 0), 3'h1, 5);
        foreach (rows[i]) begin
            go(p(1, rows[i][4], rows[i][3:1], 0), 3'h1, 5);
            if (rows[i][0]) code_exp = rows[i][3:1];
            chk({cmd_valid, cmd_code}, {rows[i][0], code_exp});
        end
        go(p(1, 0, 3'h7, 1), 3'h1, 5);
        chk({3'h0, odt_en}, 4'h1);
        go(p(0, 0, 3'h1, 1), 3'h1, 5);
        chk({1'b0, odt_en, pwr_state}, 4'h3);
        go(p(0, 0, 3'h1, 1), 3'h1, 8);
        chk({1'b0, cmd_valid, pwr_state}, 4'h3);
        go(p(1, 0, 3'h7, 0), 3'h1, 4);
        chk({1'b0, sref_exit, pwr_state}, 4'h4);
        go(p(0, 0, 3'h7, 0), 3'h5, 5);
        chk({2'h0, pwr_state}, 4'h1);
        go(p(1, 0, 3'h7, 0), 3'h5, 4);
        chk({1'b0, pd_exit, pwr_state}, 4'h4);
        go(p(0, 0, 3'h7, 0), 3'h3, 5);
        chk({2'h0, pwr_state}, 4'h1);
        go(p(0, 0, 3'h7, 0), 3'h1, 3);
        chk({2'h0, pwr_state}, 4'h2);
        go(p(1, 0, 3'h7, 0), 3'h1, 4);
        chk({1'b0, pd_exit, pwr_state}, 4'h4);
        go(p(0, 0, 3'h7, 0), 3'h1, 5);
        chk({2'h0, pwr_state}, 4'h2);
        go(p(1, 0, 3'h7, 0), 3'h1, 4);
        chk({1'b0, pd_exit, pwr_state}, 4'h4);
        go(p(0, 0, 3'h1, 0), 3'h0, 5);
        chk({2'h0, pwr_state}, 4'h0);
        go(p(1, 0, 3'h7, 0), 3'h1, 5);
        wrap_up();
    end
endmodule
